/* rtl/loop_ctrl_regs.vh */
`ifndef LOOP_CTRL_REGS_VH
`define LOOP_CTRL_REGS_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ADDR_LOOPBACK_CONTROL   5'h13
`define ADDR_RX_ERROR_COUNTER   5'h14

// ----------------------------------------
// Loopback control fields
// ----------------------------------------
`define LOOPBACK_CONTROL_RESET  16'h1041
`define LOOPBACK_CONTROL_WMASK  16'hF7C1
`define BIT_ALL_DIGITAL         12
`define BIT_LINE_DRIVER         10
`define BIT_REMOTE              9
`define BIT_RX_ISOLATE          8
`define BIT_EXT_CABLE           7
`define BIT_TX_SUPPRESS         6
`define BIT_LINK_GOOD_FORCE     0

// ----------------------------------------
// Receive error counter
// ----------------------------------------
`define RX_ERROR_COUNTER_RESET  16'h0000
`define RX_ERROR_COUNTER_MAX    16'hFFFF
`define RX_ERROR_COUNTER_ONE    16'h0001

// ----------------------------------------
// Read data
// ----------------------------------------
`define READ_DATA_IDLE          16'h0000

`endif

/* rtl/reset_sync.v */
`timescale 1ns/1ps
module reset_sync (
  input  wire clk,
  input  wire resetn,
  output wire syncResetn
);
  reg [1:0] stage_r;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage_r <= 2'h0;
    end else begin
      stage_r <= {stage_r[0], 1'h1};
    end
  end

  assign syncResetn = stage_r[1];
endmodule

/* rtl/error_counter.v */
`timescale 1ns/1ps
`include "loop_ctrl_regs.vh"
module error_counter (
  input  wire        clk,
  input  wire        rstn,
  input  wire        errorPulse,
  input  wire        clearRead,
  output wire [15:0] count
);
  reg [15:0] count_r;
  reg [15:0] count_nxt;

  // ----------------------------------------
  // Saturating count, clear on read
  // ----------------------------------------
  always @* begin
    count_nxt = count_r;
    if (clearRead) begin
      count_nxt = `RX_ERROR_COUNTER_RESET;
      if (errorPulse) begin
        count_nxt = `RX_ERROR_COUNTER_ONE;
      end
    end else if (errorPulse && (count_r != `RX_ERROR_COUNTER_MAX)) begin
      count_nxt = count_r + `RX_ERROR_COUNTER_ONE;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_r <= `RX_ERROR_COUNTER_RESET;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign count = count_r;
endmodule

/* rtl/phy_loopback_control.v */
// Operation
// - All-digital select loops MAC transmit to receive
// - All-digital needs standard loopback bit also set
// - Line-driver select plus loopback enters line-driver mode
// - Remote enable with link up returns remote data
// - Receive isolate blanks MAC data during loopback
// - External cable enable without standard loopback stops transmit cancellation
// - Transmit suppress blanks media during all-digital loopback
// - Link-good bit forces link status during standard loopback
// - Control resets 0x1041, reserved bits per map
// - Sixteen-bit receive error counter at 0x14
// - Reading counter returns value then clears it
`timescale 1ns/1ps
`include "loop_ctrl_regs.vh"
module phy_loopback_control (
  input  wire        clk,
  input  wire        resetn,
  // Register access from the management interface
  input  wire [4:0]  regAddr,
  input  wire        regWrite,
  input  wire        regRead,
  input  wire [15:0] regWriteData,
  output reg  [15:0] regReadData,
  // Datapath status inputs
  input  wire        standardLoopback,
  input  wire        linkUp,
  input  wire        linkStatusRaw,
  input  wire        frameCheckError,
  // Loopback steering outputs
  output wire        allDigitalLoopActive,
  output wire        lineDriverLoopActive,
  output wire        remoteLoopActive,
  output wire        externalCableLoopActive,
  output wire        cancellationDisable,
  output wire        receiveToMacBlank,
  output wire        transmitMediaBlank,
  output wire        linkStatusGood
);
  localparam        CONTROL_WIDTH       = 16;
  localparam [15:0] CONTROL_WRITE_MASK  = `LOOPBACK_CONTROL_WMASK;
  localparam [15:0] CONTROL_RESET_VALUE = `LOOPBACK_CONTROL_RESET;
  localparam [2:0]  SEL_ALL_DIGITAL     = 3'h5;
  localparam [2:0]  SEL_LINE_DRIVER     = 3'h6;
  localparam [2:0]  SEL_BOTH            = 3'h7;

  wire        rstn;
  wire [15:0] loopbackControl;
  wire [15:0] rxErrorCount;
  wire        anyLoopActive;
  wire        counterRead;
  wire        controlWrite;
  wire        controlRead;

  wire        allDigitalSelect;
  wire        lineDriverSelect;
  wire        remoteEnable;
  wire        receiveIsolate;
  wire        externalCableEnable;
  wire        transmitSuppress;
  wire        linkGoodForce;

  reg         allDigitalMode;
  reg         lineDriverMode;
  reg         remoteMode;
  reg         externalCableMode;
  reg         receiveBlank;
  reg         transmitBlank;
  reg         linkGood;
  reg  [15:0] readData_nxt;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  reset_sync resetSync (
    .clk        (clk),
    .resetn     (resetn),
    .syncResetn (rstn)
  );

  // ----------------------------------------
  // Register access decode
  // ----------------------------------------
  // Strobes are decoded once so the register and read paths agree on the map
  assign controlWrite = regWrite && (regAddr == `ADDR_LOOPBACK_CONTROL);
  assign controlRead  = regRead && (regAddr == `ADDR_LOOPBACK_CONTROL);
  assign counterRead  = regRead && (regAddr == `ADDR_RX_ERROR_COUNTER);

  // ----------------------------------------
  // Loopback control register
  // ----------------------------------------
  // Writable bits get a flop each; read-only reserved bits get none and read zero
  genvar bitIndex;
  generate
    for (bitIndex = 0; bitIndex < CONTROL_WIDTH; bitIndex = bitIndex + 1) begin : gControlBit
      if (CONTROL_WRITE_MASK[bitIndex]) begin : gWritable
        reg controlBit_r;
        reg controlBit_nxt;

        always @* begin
          controlBit_nxt = controlBit_r;
          if (controlWrite) begin
            controlBit_nxt = regWriteData[bitIndex];
          end
        end

        always @(posedge clk or negedge rstn) begin
          if (!rstn) begin
            controlBit_r <= CONTROL_RESET_VALUE[bitIndex];
          end else begin
            controlBit_r <= controlBit_nxt;
          end
        end

        assign loopbackControl[bitIndex] = controlBit_r;
      end else begin : gReserved
        assign loopbackControl[bitIndex] = 1'h0;
      end
    end
  endgenerate

  // ----------------------------------------
  // Loopback mode decode
  // ----------------------------------------
  assign allDigitalSelect    = loopbackControl[`BIT_ALL_DIGITAL];
  assign lineDriverSelect    = loopbackControl[`BIT_LINE_DRIVER];
  assign remoteEnable        = loopbackControl[`BIT_REMOTE];
  assign receiveIsolate      = loopbackControl[`BIT_RX_ISOLATE];
  assign externalCableEnable = loopbackControl[`BIT_EXT_CABLE];
  assign transmitSuppress    = loopbackControl[`BIT_TX_SUPPRESS];
  assign linkGoodForce       = loopbackControl[`BIT_LINK_GOOD_FORCE];

  // Line-driver takes precedence over all-digital when both are selected
  always @* begin
    allDigitalMode = 1'h0;
    lineDriverMode = 1'h0;
    case ({standardLoopback, lineDriverSelect, allDigitalSelect})
      SEL_ALL_DIGITAL: begin
        allDigitalMode = 1'h1;
      end
      SEL_LINE_DRIVER,
      SEL_BOTH: begin
        lineDriverMode = 1'h1;
      end
      default: begin
        allDigitalMode = 1'h0;
        lineDriverMode = 1'h0;
      end
    endcase
  end

  // The host is trusted to keep standard loopback clear here; gating it too
  // makes a misconfiguration fail safe rather than mix two modes
  always @* begin
    externalCableMode = 1'h0;
    if (externalCableEnable && !standardLoopback) begin
      externalCableMode = 1'h1;
    end
  end

  always @* begin
    remoteMode = 1'h0;
    if (linkUp && remoteEnable) begin
      remoteMode = 1'h1;
    end
  end

  // ----------------------------------------
  // Loopback qualifiers
  // ----------------------------------------
  assign anyLoopActive = allDigitalMode | lineDriverMode | remoteMode | externalCableMode;

  always @* begin
    receiveBlank  = 1'h0;
    transmitBlank = 1'h0;
    linkGood      = linkStatusRaw;
    if (anyLoopActive && receiveIsolate) begin
      receiveBlank = 1'h1;
    end
    if (allDigitalMode && transmitSuppress) begin
      transmitBlank = 1'h1;
    end
    if (standardLoopback && linkGoodForce) begin
      linkGood = 1'h1;
    end
  end

  // ----------------------------------------
  // Steering outputs
  // ----------------------------------------
  assign allDigitalLoopActive    = allDigitalMode;
  assign lineDriverLoopActive    = lineDriverMode;
  assign remoteLoopActive        = remoteMode;
  assign externalCableLoopActive = externalCableMode;
  assign cancellationDisable     = externalCableMode;
  assign receiveToMacBlank       = receiveBlank;
  assign transmitMediaBlank      = transmitBlank;
  assign linkStatusGood          = linkGood;

  // ----------------------------------------
  // Receive error counter
  // ----------------------------------------
  // Errors are only meaningful once the diagnostics clock is running

  error_counter errorCounter (
    .clk        (clk),
    .rstn       (rstn),
    .errorPulse (frameCheckError),
    .clearRead  (counterRead),
    .count      (rxErrorCount)
  );

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Read data holds between reads so a slow host may sample it late
  always @* begin
    readData_nxt = regReadData;
    if (controlRead) begin
      readData_nxt = loopbackControl;
    end else if (counterRead) begin
      readData_nxt = rxErrorCount;
    end else if (regRead) begin
      readData_nxt = `READ_DATA_IDLE;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regReadData <= `READ_DATA_IDLE;
    end else begin
      regReadData <= readData_nxt;
    end
  end
endmodule

/* sim/error_source.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Frame checker stand-in
// ----------------------------------------
module error_source (
  input  wire        clk,
  input  wire        load,
  input  wire [16:0] burst,
  output reg         pulse
);
  reg [16:0] left_r;
  initial begin
    left_r = 17'h00000;
    pulse  = 1'b0;
  end
  // Posedge with NBA so the design never races the pulse
  always @(posedge clk) begin
    pulse <= left_r != 17'h00000;
    if (load) left_r <= burst;
    else if (left_r != 17'h00000) left_r <= left_r - 17'h00001;
  end
endmodule

/* sim/loopback_chk.sv */
`timescale 1ns/1ps
module loopback_chk (
  input        clk,
  input        resetn,
  input  [4:0] regAddr,
  input        regRead,
  input        regWrite,
  input [15:0] regWriteData,
  input [15:0] regReadData,
  input        standardLoopback,
  input        linkUp,
  input        linkStatusRaw,
  input        frameCheckError,
  input        allDigitalLoopActive,
  input        lineDriverLoopActive,
  input        remoteLoopActive,
  input        externalCableLoopActive,
  input        cancellationDisable,
  input        receiveToMacBlank,
  input        transmitMediaBlank,
  input        linkStatusGood
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [15:0] ctrlShadow_r;
  always @(posedge clk or negedge resetn)
    if (!resetn) ctrlShadow_r <= 16'h1041;
    else if (regWrite && regAddr == 5'h13) ctrlShadow_r <= regWriteData & 16'hF7C1;
  wire anyLoop = allDigitalLoopActive | lineDriverLoopActive | remoteLoopActive
                 | externalCableLoopActive;
  sequence sClrRd;
    regRead && regAddr == 5'h14 && !frameCheckError;
  endsequence
  sequence sRd;
    regRead && regAddr == 5'h14;
  endsequence
  AST_AD: assert property (allDigitalLoopActive |-> standardLoopback)
    else $error("all digital loop without standard loopback");
  AST_LD: assert property (lineDriverLoopActive |-> !allDigitalLoopActive && standardLoopback)
    else $error("line driver loop conflict");
  AST_RM: assert property (remoteLoopActive |-> linkUp)
    else $error("remote loop without link");
  AST_EX: assert property (externalCableLoopActive |-> !standardLoopback)
    else $error("external loop with standard loopback");
  AST_CN: assert property (cancellationDisable == (ctrlShadow_r[7] && !standardLoopback))
    else $error("cancellation disable mismatch");
  AST_RB: assert property (receiveToMacBlank |-> anyLoop)
    else $error("receive blank outside loopback");
  AST_TB: assert property (transmitMediaBlank |-> allDigitalLoopActive)
    else $error("transmit blank outside all digital loop");
  AST_LS: assert property (linkStatusGood ==
    (linkStatusRaw || (standardLoopback && ctrlShadow_r[0])))
    else $error("link status mismatch");
  AST_RC: assert property (sClrRd ##1 sRd |=> regReadData == 16'h0000)
    else $error("counter not cleared by read");
  AST_ADX: assert property (allDigitalLoopActive ==
    (standardLoopback && ctrlShadow_r[12] && !ctrlShadow_r[10]))
    else $error("all digital loop mismatch");
  AST_LDX: assert property (lineDriverLoopActive == (standardLoopback && ctrlShadow_r[10]))
    else $error("line driver loop mismatch");
  AST_RMX: assert property (remoteLoopActive == (linkUp && ctrlShadow_r[9]))
    else $error("remote loop mismatch");
  AST_RBX: assert property (receiveToMacBlank == (anyLoop && ctrlShadow_r[8]))
    else $error("receive blank mismatch");
  AST_TBX: assert property (transmitMediaBlank == (allDigitalLoopActive && ctrlShadow_r[6]))
    else $error("transmit blank mismatch");
endmodule
bind phy_loopback_control loopback_chk u_chk (.*);

/* sim/phy_loopback_control_bench.sv */
`timescale 1ns/1ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin err_count++; \
  $display("Error %s exp %h got %h", n, e, a); end end
module phy_loopback_control_bench;
  logic clk, resetn, regWrite, regRead, std, lu, lr, load, fce;
  logic [4:0] regAddr;
  logic [15:0] regWriteData, regReadData, d;
  logic [16:0] burst;
  wire  [7:0] outs;
  int err_count, check_count, i;
  logic [31:0] seed;
  phy_loopback_control i_dut (.clk(clk), .resetn(resetn), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWriteData(regWriteData),
    .regReadData(regReadData), .standardLoopback(std), .linkUp(lu),
    .linkStatusRaw(lr), .frameCheckError(fce), .allDigitalLoopActive(outs[7]),
    .lineDriverLoopActive(outs[6]), .remoteLoopActive(outs[5]),
    .externalCableLoopActive(outs[4]), .cancellationDisable(outs[3]),
    .receiveToMacBlank(outs[2]), .transmitMediaBlank(outs[1]), .linkStatusGood(outs[0]));
  error_source i_err (.clk(clk), .load(load), .burst(burst), .pulse(fce));
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  function [7:0] ex(input [15:0] c, input s, input u, input r);
    reg ld, ad, rm, ec;
    begin
      ld = s & c[10];
      ad = s & c[12] & !ld;
      rm = u & c[9];
      ec = c[7] & !s;
      ex = {ad, ld, rm, ec, ec, (ad | ld | rm | ec) & c[8], ad & c[6], r | (s & c[0])};
    end
  endfunction
  task wr(input [4:0] a, input [15:0] v);
    @(negedge clk); regAddr = a; regWriteData = v; regWrite = 1'b1;
    @(negedge clk); regWrite = 1'b0;
  endtask
  task rd(input [4:0] a);
    @(negedge clk); regAddr = a; regRead = 1'b1;
    @(negedge clk); regRead = 1'b0; d = regReadData;
  endtask
  task final_report;
    if (err_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    {resetn, regWrite, regRead, std, lu, lr, load} = 7'h00;
    regAddr = 5'h00; regWriteData = 16'h0000; burst = 17'h00000; seed = 32'h0001113B;
    repeat (3) @(posedge clk);
    @(negedge clk) resetn = 1'b1;
    repeat (3) @(negedge clk);
    rd(5'h13); `CHK("control", 16'h1041, d)
    rd(5'h14); `CHK("counter", 16'h0000, d)
    rd(5'h1F); `CHK("unmapped", 16'h0000, d)
    wr(5'h13, 16'hFFFF); rd(5'h13); `CHK("mask", 16'hF7C1, d)
    for (i = 0; i < 300; i++) begin
      seed = xs(seed);
      wr(5'h13, i < 2 ? 16'hFFFF : seed[15:0]);
      {std, lu, lr} = i < 2 ? {i[0], 2'b10} : seed[18:16];
      #1 `CHK("modes", ex(i < 2 ? 16'hFFFF : seed[15:0], std, lu, lr), outs)
    end
    burst = {9'h000, seed[7:0]} + 17'h00001;
    @(negedge clk) load = 1'b1;
    @(negedge clk) load = 1'b0;
    repeat (burst + 3) @(negedge clk);
    rd(5'h14); `CHK("count", burst[15:0], d)
    @(negedge clk); regRead = 1'b1;
    repeat (2) @(negedge clk);
    regRead = 1'b0; `CHK("cleared", 16'h0000, regReadData)
    burst = 17'h00001;
    @(negedge clk) load = 1'b1;
    @(negedge clk) load = 1'b0;
    rd(5'h14); rd(5'h14); `CHK("kept", 16'h0001, d)
    burst = 17'h10005;
    @(negedge clk) load = 1'b1;
    @(negedge clk) load = 1'b0;
    repeat (65545) @(negedge clk);
    rd(5'h14); `CHK("saturate", 16'hFFFF, d)
    final_report();
  end
endmodule
